// ==== logic/catx_map.svh ====
// Register map, field positions, reset values for the CAN transmit select / acceptance slice
// Assumes byte addresses on an APB bus with 32-bit data
`ifndef CATX_MAP_SVH
`define CATX_MAP_SVH
`define CATX_OFF_TAAK 12'h000
`define CATX_OFF_TBSEL 12'h004
`define CATX_OFF_IDAC 12'h008
`define CATX_OFF_TFLG 12'h00c
`define CATX_OFF_TARQ 12'h010
`define CATX_OFF_INIT 12'h014
`define CATX_OFF_IRQ_STAT 12'h018
`define CATX_OFF_IRQ_MASK 12'h01c
`define CATX_MODE_LSB 4
`define CATX_MODE_MSB 5
`define CATX_HIT_MSB 2
`define CATX_RST_BYTE 8'h00
`define CATX_RST_TFLG 3'h7
`endif

// ==== logic/catx_pkg.sv ====
// Types for the CAN transmit select / acceptance slice
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package catx_pkg;
    typedef enum logic [1:0] {
        CATX_MODE_TWO32 = 2'h0,
        CATX_MODE_FOUR16 = 2'h1,
        CATX_MODE_EIGHT8 = 2'h2,
        CATX_MODE_CLOSED = 2'h3
    } catx_mode_t;
    typedef enum logic [1:0] {
        CATX_INIT_RUN = 2'h0,
        CATX_INIT_REQ = 2'h1,
        CATX_INIT_ACTIVE = 2'h3,
        CATX_INIT_LEAVE = 2'h2
    } catx_init_t;
endpackage
`default_nettype wire

// ==== logic/catx_ctrl.sv ====
// CAN transmit buffer select, abort acknowledge and acceptance control slice
// Assumes an APB master on sys_clk; protocol engine drives the tx and rx events
`include "catx_map.svh"
`default_nettype none
// Function
// - Abort acknowledge register held at zero while init mode active.
// - Abort acknowledge readable anytime; writes ignored.
// - Per-buffer abort acknowledge set when that buffer's message was aborted.
// - Abort acknowledge bit clears when software clears the same empty flag.
// - Select register held reset in init; writable only when request and ack clear.
// - Select reads return only lowest set bit.
// - Lowest set select bit picks the buffer mapped into the window.
// - Window accesses blocked while selected buffer is scheduled.
// - No window accesses when no buffer selected.
// - Acceptance control readable anytime, writable only in init mode.
// - Hit index bits read-only, even in init mode.
// - Mode 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// - Closed mode accepts no message; foreground buffer never reloaded.
// - Three-bit hit field gives accepting filter index 0 to 7.
// - Hit index tracks foreground message, updated on each matching shift-in unless mode is closed or init mode is active.
// - Empty flag set on send or granted abort; abort request then cleared.
// - Abort granted only if not started, or after lost arbitration or error.
module catx_ctrl #(
    parameter int NUM_TX = 3,
    parameter int INIT_DELAY = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] tx_sent,
    input wire logic [2:0] tx_started,
    input wire logic [2:0] tx_failed,
    input wire logic [2:0] tx_abort_point,
    input wire logic rx_shift_in,
    input wire logic rx_match,
    input wire logic [2:0] rx_filter_index,
    input wire logic window_access,
    output logic [2:0] window_buffer,
    output logic window_select_valid,
    output logic window_grant,
    output logic [1:0] acceptance_mode,
    output logic rx_foreground_load,
    output logic init_acknowledge,
    output logic irq
);
    // ==========================================================
    // State
    // ==========================================================
    logic [2:0] tx_buffer_empty;
    logic [2:0] abort_request;
    logic [2:0] abort_acknowledged;
    logic [2:0] tx_select;
    logic [1:0] mode;
    logic [2:0] acceptance_hit_index;
    logic init_request;
    catx_pkg::catx_init_t init_state;
    logic [3:0] init_cnt;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic init_mode;
    logic run_mode;
    logic wr;
    logic rd;
    logic [2:0] granted;
    logic [2:0] done;
    logic [2:0] tflg_clr;
    logic [2:0] sel_low;
    logic mapped;
    logic [31:0] next_prdata;

    // Lowest set bit isolation, used for read and mapping
    function automatic logic [2:0] lowest_bit(input logic [2:0] v);
        lowest_bit = v & (~v + 3'h1);
    endfunction

    // ==========================================================
    // Decode
    // ==========================================================
    assign init_mode = init_request & init_acknowledge;
    assign run_mode = ~init_request & ~init_acknowledge;
    assign wr = psel & penable & pwrite & pready & pstrb[0];
    assign rd = psel & penable & ~pwrite;
    // Abort grant only before start or after a failed attempt
    assign granted = abort_request & ~tx_buffer_empty & tx_abort_point
                   & (~tx_started | tx_failed);
    assign done = (tx_sent | granted) & ~tx_buffer_empty;
    assign tflg_clr = (wr && paddr == `CATX_OFF_TFLG && run_mode) ? pwdata[2:0] : 3'h0;
    assign sel_low = lowest_bit(tx_select);
    assign mapped = |sel_low;

    // ==========================================================
    // Init handshake
    // ==========================================================
    // Request bit from software
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            init_request <= 1'b1;
        else if (wr && paddr == `CATX_OFF_INIT)
            init_request <= pwdata[0];
    end

    // Acknowledge follows request after a short delay
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            init_state <= catx_pkg::CATX_INIT_RUN;
            init_cnt <= 4'h0;
            init_acknowledge <= 1'b0;
        end
        else
        begin
            case (init_state)
                catx_pkg::CATX_INIT_RUN:
                    if (init_request)
                    begin
                        init_state <= catx_pkg::CATX_INIT_REQ;
                        init_cnt <= 4'h0;
                    end
                catx_pkg::CATX_INIT_REQ:
                    if (init_cnt == 4'(INIT_DELAY))
                    begin
                        init_state <= catx_pkg::CATX_INIT_ACTIVE;
                        init_acknowledge <= 1'b1;
                    end
                    else
                        init_cnt <= init_cnt + 4'h1;
                catx_pkg::CATX_INIT_ACTIVE:
                    if (!init_request)
                        init_state <= catx_pkg::CATX_INIT_LEAVE;
                catx_pkg::CATX_INIT_LEAVE:
                begin
                    init_state <= catx_pkg::CATX_INIT_RUN;
                    init_acknowledge <= 1'b0;
                end
                default:
                    init_state <= catx_pkg::CATX_INIT_RUN;
            endcase
        end
    end

    // ==========================================================
    // Transmit flags
    // ==========================================================
    // Empty flags: set on completion, cleared by software write of one
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tx_buffer_empty <= `CATX_RST_TFLG;
        else if (init_mode)
            tx_buffer_empty <= `CATX_RST_TFLG;
        else
            tx_buffer_empty <= (tx_buffer_empty & ~tflg_clr) | done;
    end

    // Abort requests: software sets, cleared when the empty flag sets
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            abort_request <= 3'h0;
        else if (init_mode)
            abort_request <= 3'h0;
        else if (wr && paddr == `CATX_OFF_TARQ && run_mode)
            abort_request <= (abort_request | (pwdata[2:0] & ~tx_buffer_empty)) & ~done;
        else
            abort_request <= abort_request & ~done;
    end

    // Abort acknowledge: hardware only, set wins over clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            abort_acknowledged <= 3'(`CATX_RST_BYTE);
        else if (init_mode)
            abort_acknowledged <= 3'h0;
        else
            abort_acknowledged <= (abort_acknowledged & ~tflg_clr) | granted;
    end

    // ==========================================================
    // Buffer select and window
    // ==========================================================
    // Select register, writable only in run mode
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tx_select <= 3'h0;
        else if (init_mode)
            tx_select <= 3'h0;
        else if (wr && paddr == `CATX_OFF_TBSEL && run_mode)
            tx_select <= pwdata[2:0];
    end

    // Window mapping and access grant
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            window_buffer <= 3'h0;
            window_select_valid <= 1'b0;
            window_grant <= 1'b0;
        end
        else
        begin
            window_buffer <= sel_low;
            window_select_valid <= mapped;
            window_grant <= window_access & mapped
                          & |(sel_low & tx_buffer_empty);
        end
    end

    // ==========================================================
    // Acceptance control
    // ==========================================================
    // Mode field, writable only in init mode
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mode <= 2'h0;
        else if (wr && paddr == `CATX_OFF_IDAC && init_mode)
            mode <= pwdata[`CATX_MODE_MSB:`CATX_MODE_LSB];
    end

    assign acceptance_mode = mode; // Straight from the mode flip-flops

    // Hit index and foreground reload
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            acceptance_hit_index <= 3'h0;
            rx_foreground_load <= 1'b0;
        end
        else if (init_mode)
        begin
            acceptance_hit_index <= 3'h0;
            rx_foreground_load <= 1'b0;
        end
        else
        begin
            rx_foreground_load <= rx_shift_in & rx_match
                                & (mode != catx_pkg::CATX_MODE_CLOSED);
            if (rx_shift_in && rx_match && mode != catx_pkg::CATX_MODE_CLOSED)
                acceptance_hit_index <= rx_filter_index;
        end
    end

    // ==========================================================
    // Interrupts
    // ==========================================================
    // Sticky status per buffer done, write one to clear, set wins
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            irq_stat <= 3'h0;
        else if (wr && paddr == `CATX_OFF_IRQ_STAT)
            irq_stat <= (irq_stat & ~pwdata[2:0]) | done;
        else
            irq_stat <= irq_stat | done;
    end

    // Mask register and interrupt line
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `CATX_OFF_IRQ_MASK)
                irq_mask <= pwdata[2:0];
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ==========================================================
    // APB slave
    // ==========================================================
    // Read mux
    always_comb
    begin
        next_prdata = 32'h0;
        case (paddr)
            `CATX_OFF_TAAK: next_prdata = {29'h0, abort_acknowledged};
            `CATX_OFF_TBSEL: next_prdata = {29'h0, sel_low};
            `CATX_OFF_IDAC: next_prdata = {26'h0, mode, 1'b0, acceptance_hit_index};
            `CATX_OFF_TFLG: next_prdata = {29'h0, tx_buffer_empty};
            `CATX_OFF_TARQ: next_prdata = {29'h0, abort_request};
            `CATX_OFF_INIT: next_prdata = {30'h0, init_acknowledge, init_request};
            `CATX_OFF_IRQ_STAT: next_prdata = {29'h0, irq_stat};
            `CATX_OFF_IRQ_MASK: next_prdata = {29'h0, irq_mask};
            default: next_prdata = 32'h0;
        endcase
    end

    // One wait state: ready in the second access cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            if (rd && !pready)
                prdata <= next_prdata;
            pslverr <= psel & penable & ~pready & (paddr > `CATX_OFF_IRQ_MASK
                     || paddr[1:0] != 2'h0);
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_ack_init;
        @(posedge sys_clk) disable iff (rst)
        init_mode |=> abort_acknowledged == 3'h0;
    endproperty
    a_ack_init: assert property (p_ack_init) else $error("ack not held in init");

    property p_ack_set;
        @(posedge sys_clk) disable iff (rst)
        (!init_mode && granted != 3'h0) |=> (abort_acknowledged & $past(granted)) == $past(granted);
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("ack not set on abort");

    property p_ack_clr;
        @(posedge sys_clk) disable iff (rst)
        (!init_mode && tflg_clr != 3'h0 && granted == 3'h0)
            |=> (abort_acknowledged & $past(tflg_clr)) == 3'h0;
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ack not cleared");

    property p_sel_hold;
        @(posedge sys_clk) disable iff (rst)
        !run_mode && !init_mode |=> tx_select == $past(tx_select);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select changed mid handshake");

    property p_win_map;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> window_buffer == lowest_bit($past(tx_select));
    endproperty
    a_win_map: assert property (p_win_map) else $error("window map wrong");

    property p_win_block;
        @(posedge sys_clk) disable iff (rst)
        (sel_low & tx_buffer_empty) == 3'h0 |=> !window_grant;
    endproperty
    a_win_block: assert property (p_win_block) else $error("blocked window granted");

    property p_mode_lock;
        @(posedge sys_clk) disable iff (rst)
        !init_mode |=> acceptance_mode == $past(acceptance_mode);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("mode changed outside init");

    property p_closed;
        @(posedge sys_clk) disable iff (rst)
        mode == catx_pkg::CATX_MODE_CLOSED |=> !rx_foreground_load;
    endproperty
    a_closed: assert property (p_closed) else $error("closed filter reloaded");

    sequence s_shift;
        rx_shift_in && rx_match && !init_mode && mode != catx_pkg::CATX_MODE_CLOSED;
    endsequence
    property p_hit;
        @(posedge sys_clk) disable iff (rst)
        s_shift |=> acceptance_hit_index == $past(rx_filter_index);
    endproperty
    a_hit: assert property (p_hit) else $error("hit index not updated");

    property p_abort_clr;
        @(posedge sys_clk) disable iff (rst)
        (!init_mode && done != 3'h0) |=> (abort_request & $past(done)) == 3'h0;
    endproperty
    a_abort_clr: assert property (p_abort_clr) else $error("abort request not cleared");
endmodule
`default_nettype wire

// ==== verification/catx_engine_model.sv ====
// Stand-in for the protocol engine that raises transmit and receive events
// Assumes its tasks are entered right after a rising sys_clk edge
`default_nettype none
module catx_engine_model (
    input wire logic sys_clk,
    output logic [2:0] tx_sent,
    output logic [2:0] tx_started,
    output logic [2:0] tx_failed,
    output logic [2:0] tx_abort_point,
    output logic rx_shift_in,
    output logic rx_match,
    output logic [2:0] rx_filter_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Quiet event lines
    initial
    begin
        tx_sent = 3'h0;
        tx_started = 3'h0;
        tx_failed = 3'h0;
        tx_abort_point = 3'h0;
        rx_shift_in = 1'b0;
        rx_match = 1'b0;
        rx_filter_index = 3'h5;
    end
    // One cycle of transmit events, then quiet
    task automatic tx_event(input logic [2:0] s, st, f, pt);
        tx_sent <= s;
        tx_started <= st;
        tx_failed <= f;
        tx_abort_point <= pt;
        @(posedge sys_clk);
        tx_sent <= 3'h0;
        tx_started <= 3'h0;
        tx_failed <= 3'h0;
        tx_abort_point <= 3'h0;
    endtask
    // One message shifted in; index line scrambled once released
    task automatic rx_msg(input logic m, input logic [2:0] idx);
        rx_shift_in <= 1'b1;
        rx_match <= m;
        rx_filter_index <= idx;
        @(posedge sys_clk);
        rx_shift_in <= 1'b0;
        rx_match <= ~m;
        rx_filter_index <= ~idx;
    endtask
endmodule
`default_nettype wire

// ==== verification/can_tx_select_abort_ack_filter_ctrl_test.sv ====
// Self-checking bench for the transmit select / acceptance slice
// Assumes the design and the engine model are compiled first
`include "catx_map.svh"
`default_nettype none
module can_tx_select_abort_ack_filter_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, window_access;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] tx_sent, tx_started, tx_failed, tx_abort_point, rx_filter_index;
    logic rx_shift_in, rx_match, window_select_valid, window_grant;
    logic rx_foreground_load, init_acknowledge, irq;
    logic [2:0] window_buffer, v, lo;
    logic [1:0] acceptance_mode, m;
    logic [32:0] exp_q[$];
    integer seed = 32'h7dc2abb5;
    int failures = 0;
    int comparisons = 0;
    // ==========================================
    // Design and engine stand-in
    catx_ctrl #(.NUM_TX(3), .INIT_DELAY(2)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_sent(tx_sent), .tx_started(tx_started),
        .tx_failed(tx_failed), .tx_abort_point(tx_abort_point),
        .rx_shift_in(rx_shift_in), .rx_match(rx_match), .rx_filter_index(rx_filter_index),
        .window_access(window_access), .window_buffer(window_buffer),
        .window_select_valid(window_select_valid), .window_grant(window_grant),
        .acceptance_mode(acceptance_mode), .rx_foreground_load(rx_foreground_load),
        .init_acknowledge(init_acknowledge), .irq(irq)
    );
    catx_engine_model eng_u (
        .sys_clk(sys_clk), .tx_sent(tx_sent), .tx_started(tx_started),
        .tx_failed(tx_failed), .tx_abort_point(tx_abort_point),
        .rx_shift_in(rx_shift_in), .rx_match(rx_match), .rx_filter_index(rx_filter_index)
    );
    // ==========================================
    // Clock, 4 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Compare and count
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        comparisons++;
        if (seen !== want)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // Only the watchdog ends a wait for pready
        while (pready !== 1'b1)
            @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Write with random upper bits; read with a noted {pslverr, data}
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        r = $random(seed);
        apb(a, 1'b1, {r[31:8], d});
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] want);
        exp_q.push_back(want);
        apb(a, 1'b0, 32'h0);
    endtask
    // Init handshake wait, bounded
    task automatic wait_ack(input logic val);
        int n;
        n = 0;
        while (init_acknowledge !== val && n < 64)
        begin
            @(posedge sys_clk);
            n++;
        end
        check(33'(init_acknowledge), 33'(val));
    endtask
    // Window access pulse, grant seen one cycle later
    task automatic win(input logic want);
        window_access <= 1'b1;
        @(posedge sys_clk);
        window_access <= 1'b0;
        @(negedge sys_clk);
        check(33'(window_grant), 33'(want));
        @(posedge sys_clk);
    endtask
    // Read monitor: oldest note against each completed read
    always @(posedge sys_clk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
            check({pslverr, prdata}, exp_q.pop_front());
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        final_report();
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        window_access = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        wait_ack(1'b1);
        rd(`CATX_OFF_TAAK, 33'h0);
        rd(`CATX_OFF_TBSEL, 33'h0);
        rd(`CATX_OFF_IDAC, 33'h0);
        rd(`CATX_OFF_TFLG, 33'h7);
        // Every mode in init; hit bits written high stay zero
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i + 3);
            wr(`CATX_OFF_IDAC, {2'h0, m, 4'h7});
            @(negedge sys_clk);
            check(33'(acceptance_mode), 33'(m));
            @(posedge sys_clk);
            rd(`CATX_OFF_IDAC, 33'({m, 4'h0}));
        end
        wr(`CATX_OFF_TBSEL, 8'h1);
        rd(`CATX_OFF_TBSEL, 33'h0);
        // Run mode: mode locked, unmapped places refused
        wr(`CATX_OFF_INIT, 8'h0);
        wait_ack(1'b0);
        wr(`CATX_OFF_IDAC, 8'h10);
        rd(`CATX_OFF_IDAC, 33'h20);
        rd(12'h020, 33'h100000000);
        rd(12'h006, 33'h100000000);
        // Select: all codes plus a random one
        for (int i = 0; i < 9; i++)
        begin
            v = (i < 8) ? 3'(i) : 3'($random(seed));
            lo = v[0] ? 3'h1 : (v[1] ? 3'h2 : {v[2], 2'h0});
            wr(`CATX_OFF_TBSEL, {5'h0, v});
            rd(`CATX_OFF_TBSEL, 33'(lo));
            @(negedge sys_clk);
            check(33'(window_buffer), 33'(lo));
            check(33'(window_select_valid), 33'(v != 3'h0));
            @(posedge sys_clk);
        end
        // Window access: free, scheduled, none selected
        wr(`CATX_OFF_TBSEL, 8'h3);
        win(1'b1);
        wr(`CATX_OFF_TFLG, 8'h1);
        rd(`CATX_OFF_TFLG, 33'h6);
        win(1'b0);
        wr(`CATX_OFF_TBSEL, 8'h0);
        win(1'b0);
        // Abort refused after start, granted after failure
        wr(`CATX_OFF_TARQ, 8'h1);
        rd(`CATX_OFF_TARQ, 33'h1);
        eng_u.tx_event(3'h0, 3'h1, 3'h0, 3'h1);
        rd(`CATX_OFF_TAAK, 33'h0);
        eng_u.tx_event(3'h0, 3'h1, 3'h1, 3'h1);
        rd(`CATX_OFF_TAAK, 33'h1);
        rd(`CATX_OFF_TFLG, 33'h7);
        rd(`CATX_OFF_TARQ, 33'h0);
        wr(`CATX_OFF_TAAK, 8'h2);
        rd(`CATX_OFF_TAAK, 33'h1);
        wr(`CATX_OFF_TFLG, 8'h1);
        rd(`CATX_OFF_TAAK, 33'h0);
        wr(`CATX_OFF_TARQ, 8'h1);
        eng_u.tx_event(3'h0, 3'h0, 3'h0, 3'h1);
        rd(`CATX_OFF_TAAK, 33'h1);
        wr(`CATX_OFF_TFLG, 8'h2);
        eng_u.tx_event(3'h2, 3'h2, 3'h0, 3'h0);
        rd(`CATX_OFF_TFLG, 33'h7);
        rd(`CATX_OFF_TAAK, 33'h1);
        // Interrupt: set, masked, unmasked, cleared
        wr(`CATX_OFF_IRQ_MASK, 8'h0);
        wr(`CATX_OFF_IRQ_STAT, 8'h7);
        wr(`CATX_OFF_TFLG, 8'h4);
        eng_u.tx_event(3'h4, 3'h4, 3'h0, 3'h0);
        rd(`CATX_OFF_IRQ_STAT, 33'h4);
        check(33'(irq), 33'h0);
        wr(`CATX_OFF_IRQ_MASK, 8'h4);
        @(negedge sys_clk);
        check(33'(irq), 33'h1);
        @(posedge sys_clk);
        wr(`CATX_OFF_IRQ_STAT, 8'h4);
        @(negedge sys_clk);
        check(33'(irq), 33'h0);
        @(posedge sys_clk);
        // Receive hits in eight-filter mode
        wr(`CATX_OFF_TBSEL, 8'h4);
        for (int i = 0; i < 3; i++)
        begin
            v = (i < 2) ? 3'($random(seed)) : v;
            eng_u.rx_msg(i < 2, (i < 2) ? v : ~v);
            @(negedge sys_clk);
            check(33'(rx_foreground_load), 33'(i < 2));
            @(posedge sys_clk);
            rd(`CATX_OFF_IDAC, 33'({5'h4, v}));
        end
        // Init again clears state; closed filter takes nothing
        wr(`CATX_OFF_INIT, 8'h1);
        wait_ack(1'b1);
        rd(`CATX_OFF_TAAK, 33'h0);
        rd(`CATX_OFF_TBSEL, 33'h0);
        rd(`CATX_OFF_IDAC, 33'h20);
        wr(`CATX_OFF_IDAC, 8'h30);
        wr(`CATX_OFF_INIT, 8'h0);
        wait_ack(1'b0);
        eng_u.rx_msg(1'b1, 3'h5);
        @(negedge sys_clk);
        check(33'(rx_foreground_load), 33'h0);
        @(posedge sys_clk);
        rd(`CATX_OFF_IDAC, 33'h30);
        final_report();
    end
endmodule
`default_nettype wire
